// [rtl/drs_sequencer.sv]
// dual rail power sequencer and supply supervisor with ahb-lite registers
//
// Contract
// - active-low reset follows rail b, manual inputs
// - rail b below 95% drives reset low
// - enable high: rails off, flags low
// - order low: rail a first, b after 83%
// - order high: rail b first, a after 83%
// - good flag high at rail a 95%
// - both rails good, manual high: release after 120ms
// - enable high again powers everything down
// - manual reset a low forces reset, rails stay
// - manual a released: reset released after 120ms
// - manual inputs active low, pulled up, either resets
// - order select defaults high through pull-up
// - leading rail below 83% turns dependent off
// - good flag low below rail a 95%
`timescale 1ns/1ps
`default_nettype none
module drs_sequencer #(
	parameter int unsigned RELEASE_CYC = drs_pkg::RELEASE_CYC_DFLT
) (
	input wire logic ref_clk_i,
	input wire logic rst_b_i,
	input wire logic clk_en_i,
	// control pins
	input wire logic enable_n_i,
	input wire logic order_select_i,
	input wire logic manual_reset_a_n_i,
	input wire logic manual_reset_b_n_i,
	// comparator levels
	input wire logic rail_a_above83_i,
	input wire logic rail_a_above95_i,
	input wire logic rail_b_above83_i,
	input wire logic rail_b_above95_i,
	// regulator enables and open-drain pins
	output logic rail_a_output_on_o,
	output logic rail_b_output_on_o,
	output logic rail_a_good_flag_o,
	output logic rail_a_good_flag_oe_o,
	output logic supply_supervisor_rst_n_o,
	output logic supply_supervisor_rst_n_oe_o,
	// ahb-lite slave
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic hready_i,
	input wire logic [31:0] hwdata_i,
	output logic [31:0] hrdata_o,
	output logic hreadyout_o,
	output logic hresp_o,
	output logic irq_o
);
	import drs_pkg::*;

	drs_regs_type s_r;
	drs_regs_type s_nxt;
	drs_pins_type pins;
	drs_ahb_in_type ahb;

	localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(RELEASE_CYC - 1);

	// state of every register after reset; synchronisers idle at the pull-up level
	function automatic drs_regs_type reset_state();
		drs_regs_type s;
		s = '0;
		s.sync1 = '1;
		s.sync2 = '1;
		s.fsm = ST_OFF;
		s.lead_b = 1'b1;
		s.rail_a_on = 1'b0;
		s.rail_b_on = 1'b0;
		s.good = 1'b0;
		s.cnt = '0;
		s.released = 1'b0;
		s.irq_stat = '0;
		s.irq_en = IRQ_EN_RST;
		s.hold = CTRL_HOLD_RST;
		s.wr_pend = 1'b0;
		s.wr_addr = 8'h00;
		s.hrdata = 32'h0000_0000;
		return s;
	endfunction

	// one-cycle event from the rise of a level
	function automatic logic edge_up(input logic now, input logic was);
		return now && !was;
	endfunction

	// a rail is driven when both are on, or when it is the leading rail
	function automatic logic rail_driven(input drs_state_type st, input logic lead_b, input logic is_b);
		logic on;
		on = 1'b0;
		case (st)
			ST_BOTH: on = 1'b1;
			ST_LEAD: on = (lead_b == is_b);
			default: on = 1'b0;
		endcase
		return on;
	endfunction

	// status word: synced pins, supervisor, rails and state
	function automatic logic [31:0] status_word(input drs_regs_type s);
		return {16'h0000,
			s.sync2,
			s.released,
			s.good,
			s.rail_b_on,
			s.rail_a_on,
			s.lead_b,
			s.fsm};
	endfunction

	function automatic logic [31:0] read_mux(input drs_regs_type s, input logic [7:0] a);
		logic [31:0] v;
		v = 32'h0000_0000;
		case (a)
			OFS_STATUS: begin
				v = status_word(s);
			end
			OFS_IRQ_STAT: begin
				v = {27'h0000000, s.irq_stat};
			end
			// write-only, reads as zero
			OFS_IRQ_CLR: begin
				v = 32'h0000_0000;
			end
			OFS_IRQ_EN: begin
				v = {27'h0000000, s.irq_en};
			end
			OFS_CTRL: begin
				v = {31'h00000000, s.hold};
			end
			default: begin
				v = 32'h0000_0000;
			end
		endcase
		return v;
	endfunction

	assign pins = '{
		en_n: enable_n_i,
		order: order_select_i,
		mra_n: manual_reset_a_n_i,
		mrb_n: manual_reset_b_n_i,
		a83: rail_a_above83_i,
		a95: rail_a_above95_i,
		b83: rail_b_above83_i,
		b95: rail_b_above95_i
	};

	assign ahb = '{
		hsel: hsel_i,
		haddr: haddr_i,
		htrans: htrans_i,
		hwrite: hwrite_i,
		hsize: hsize_i,
		hready: hready_i,
		hwdata: hwdata_i
	};

	always_comb begin
		logic lead83;
		logic rel_cond;
		logic addr_ok;
		logic rails_good;
		logic manual_high;
		logic [EV_W-1:0] ev;
		logic [EV_W-1:0] clr;
		lead83 = 1'b0;
		rel_cond = 1'b0;
		addr_ok = 1'b0;
		rails_good = 1'b0;
		manual_high = 1'b0;
		ev = '0;
		clr = '0;
		s_nxt = s_r;
		// two-stage synchroniser, stage one read only by stage two
		s_nxt.sync1 = pins;
		s_nxt.sync2 = s_r.sync1;

		// off: both regulators off and flags low
		// leading: only the rail chosen on enable runs
		// both: the dependent rail follows once the leader passed 83%
		if (s_r.lead_b) begin
			lead83 = s_r.sync2.b83;
		end else begin
			lead83 = s_r.sync2.a83;
		end
		case (s_r.fsm)
			ST_OFF: begin
				if (!s_r.sync2.en_n) begin
					s_nxt.fsm = ST_LEAD;
					s_nxt.lead_b = s_r.sync2.order;
				end
			end
			ST_LEAD: begin
				if (lead83) begin
					s_nxt.fsm = ST_BOTH;
				end
			end
			ST_BOTH: begin
				if (!lead83) begin
					s_nxt.fsm = ST_LEAD;
					ev[EV_DEP_OFF] = 1'b1;
				end
			end
			default: begin
				s_nxt.fsm = ST_OFF;
			end
		endcase
		if (s_r.sync2.en_n) begin
			s_nxt.fsm = ST_OFF;
		end

		// rail enables follow the next state
		s_nxt.rail_a_on = rail_driven(s_nxt.fsm, s_nxt.lead_b, 1'b0);
		s_nxt.rail_b_on = rail_driven(s_nxt.fsm, s_nxt.lead_b, 1'b1);

		// good flag tracks rail a comparator while enabled
		s_nxt.good = (s_nxt.fsm != ST_OFF) && s_r.sync2.a95;
		// good flag events for the sticky status
		ev[EV_GOOD_UP] = edge_up(s_nxt.good, s_r.good);
		ev[EV_GOOD_DN] = edge_up(s_r.good, s_nxt.good);

		// supervisor: both rails good, both manual inputs high, no software hold
		rails_good = s_r.sync2.a95 && s_r.sync2.b95;
		manual_high = s_r.sync2.mra_n && s_r.sync2.mrb_n;
		rel_cond = (s_nxt.fsm != ST_OFF) && rails_good && manual_high && !s_r.hold;
		// counter holds at its last value once released
		if (!rel_cond) begin
			s_nxt.cnt = '0;
			s_nxt.released = 1'b0;
		end else if (s_r.cnt == CNT_LAST) begin
			s_nxt.released = 1'b1;
		end else if (!s_r.released) begin
			s_nxt.cnt = s_r.cnt + CNT_W'(1);
		end
		ev[EV_REL] = edge_up(s_nxt.released, s_r.released);
		ev[EV_ASSERT] = edge_up(s_r.released, s_nxt.released);

		// ahb data phase of a write
		s_nxt.wr_pend = 1'b0;
		if (s_r.wr_pend) begin
			// unmapped offsets are ignored
			case (s_r.wr_addr)
				OFS_IRQ_CLR: begin
					clr = ahb.hwdata[EV_W-1:0];
				end
				OFS_IRQ_EN: begin
					s_nxt.irq_en = ahb.hwdata[EV_W-1:0];
				end
				OFS_CTRL: begin
					s_nxt.hold = ahb.hwdata[CTRL_HOLD_BIT];
				end
				default: begin
					clr = '0;
				end
			endcase
		end
		// a new event wins over a clear in the same cycle
		s_nxt.irq_stat = (s_r.irq_stat & ~clr) | ev;

		// ahb address phase; read data is registered for the data phase
		addr_ok = ahb.hsel && ahb.htrans[1] && ahb.hready;
		if (addr_ok) begin
			s_nxt.wr_pend = ahb.hwrite;
			s_nxt.wr_addr = ahb.haddr[7:0];
			if (ahb.hwrite) begin
				s_nxt.hrdata = 32'h0000_0000;
			end else begin
				s_nxt.hrdata = read_mux(s_r, ahb.haddr[7:0]);
			end
		end
	end

	// reset acts even while the clock enable is low
	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			s_r <= reset_state();
		end else if (clk_en_i) begin
			s_r <= s_nxt;
		end
	end

	// regulator enables straight from their flip-flops
	assign rail_a_output_on_o = s_r.rail_a_on;
	assign rail_b_output_on_o = s_r.rail_b_on;

	// open drain pins only ever pull low
	assign rail_a_good_flag_o = 1'b0;
	assign rail_a_good_flag_oe_o = !s_r.good;
	assign supply_supervisor_rst_n_o = 1'b0;
	assign supply_supervisor_rst_n_oe_o = !s_r.released;

	assign hrdata_o = s_r.hrdata;
	// a frozen block stalls the bus rather than lose a transfer
	assign hreadyout_o = clk_en_i;
	assign hresp_o = 1'b0;
	// level interrupt: any enabled sticky bit
	assign irq_o = |(s_r.irq_stat & s_r.irq_en);
endmodule // drs_sequencer
`default_nettype wire

// [rtl/drs_pkg.sv]
// constants and types of the dual rail sequencer and supervisor
package drs_pkg;
	// timing
	localparam int unsigned CLK_HZ = 40_000_000;
	localparam int unsigned RELEASE_MS = 120;
	localparam int unsigned RELEASE_CYC_DFLT = (CLK_HZ / 1000) * RELEASE_MS;
	localparam int unsigned CNT_W = 23;
	// register byte offsets
	localparam logic [7:0] OFS_STATUS = 8'h00;
	localparam logic [7:0] OFS_IRQ_STAT = 8'h04;
	localparam logic [7:0] OFS_IRQ_CLR = 8'h08;
	localparam logic [7:0] OFS_IRQ_EN = 8'h0C;
	localparam logic [7:0] OFS_CTRL = 8'h10;
	// event bit positions
	localparam int unsigned EV_W = 5;
	localparam int unsigned EV_REL = 0;
	localparam int unsigned EV_ASSERT = 1;
	localparam int unsigned EV_GOOD_UP = 2;
	localparam int unsigned EV_GOOD_DN = 3;
	localparam int unsigned EV_DEP_OFF = 4;
	// reset values
	localparam logic [EV_W-1:0] IRQ_EN_RST = 5'h00;
	localparam logic CTRL_HOLD_RST = 1'b0;
	// control register field
	localparam int unsigned CTRL_HOLD_BIT = 0;

	typedef enum logic [2:0] {
		ST_OFF = 3'b001,
		ST_LEAD = 3'b010,
		ST_BOTH = 3'b100
	} drs_state_type;

	// pin samples, all from outside the clock domain
	typedef struct packed {
		logic en_n;
		logic order;
		logic mra_n;
		logic mrb_n;
		logic a83;
		logic a95;
		logic b83;
		logic b95;
	} drs_pins_type;

	typedef struct packed {
		logic hsel;
		logic [31:0] haddr;
		logic [1:0] htrans;
		logic hwrite;
		logic [2:0] hsize;
		logic hready;
		logic [31:0] hwdata;
	} drs_ahb_in_type;

	typedef struct packed {
		drs_pins_type sync1;
		drs_pins_type sync2;
		drs_state_type fsm;
		logic lead_b;
		logic rail_a_on;
		logic rail_b_on;
		logic good;
		logic [CNT_W-1:0] cnt;
		logic released;
		logic [EV_W-1:0] irq_stat;
		logic [EV_W-1:0] irq_en;
		logic hold;
		logic wr_pend;
		logic [7:0] wr_addr;
		logic [31:0] hrdata;
	} drs_regs_type;
endpackage : drs_pkg

// [tb/drs_rail_model.sv]
// regulator ramp model that drives the threshold comparators
`timescale 1ns/1ps
`default_nettype none
module drs_rail_model (
	input wire logic clk_i,
	input wire logic on_i,
	input wire logic fault_i,
	output logic above83_o,
	output logic above95_o
);
	int n = 0;
	// ramps while switched on, collapses at once when switched off
	always_ff @(posedge clk_i) n <= on_i ? (n < 6 ? n + 1 : n) : 0;
	assign above83_o = !fault_i && n >= 3;
	assign above95_o = !fault_i && n >= 6;
endmodule // drs_rail_model
`default_nettype wire

// [tb/drs_monitor.sv]
// pin-level checker of the sequencer and supervisor
`timescale 1ns/1ps
`default_nettype none
module drs_monitor #(parameter int unsigned RELEASE_CYC = 20) (
	input wire logic ref_clk_i,
	input wire logic rst_b_i,
	input wire logic enable_n_i,
	input wire logic manual_reset_a_n_i,
	input wire logic manual_reset_b_n_i,
	input wire logic rail_a_above83_i,
	input wire logic rail_a_above95_i,
	input wire logic rail_b_above83_i,
	input wire logic rail_b_above95_i,
	input wire logic rail_a_output_on_o,
	input wire logic rail_b_output_on_o,
	input wire logic rail_a_good_flag_oe_o,
	input wire logic supply_supervisor_rst_n_oe_o
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!rst_b_i);
	wire logic ok = !enable_n_i && manual_reset_a_n_i && manual_reset_b_n_i && rail_a_above95_i && rail_b_above95_i;
	int n = 0;
	always_ff @(posedge ref_clk_i) n <= ok ? n + 1 : 0;
	sequence s_off; enable_n_i[*5]; endsequence
	property p_off; s_off |-> !rail_a_output_on_o && !rail_b_output_on_o && supply_supervisor_rst_n_oe_o; endproperty
	a_off: assert property (p_off) else $error("rails not off");
	property p_b95; (!rail_b_above95_i)[*5] |-> supply_supervisor_rst_n_oe_o; endproperty
	a_b95: assert property (p_b95) else $error("reset not held on rail b");
	property p_mr; (!(manual_reset_a_n_i && manual_reset_b_n_i))[*5] |-> supply_supervisor_rst_n_oe_o; endproperty
	a_mr: assert property (p_mr) else $error("manual reset ignored");
	property p_good; (!enable_n_i && rail_a_above95_i)[*5] |-> !rail_a_good_flag_oe_o; endproperty
	a_good: assert property (p_good) else $error("good flag late");
	property p_bad; (!rail_a_above95_i)[*5] |-> rail_a_good_flag_oe_o; endproperty
	a_bad: assert property (p_bad) else $error("good flag stuck");
	property p_seq; $rose(rail_b_output_on_o) && rail_a_output_on_o |-> $past(rail_a_above83_i, 3); endproperty
	a_seq: assert property (p_seq) else $error("rail b early");
	property p_seqb; $rose(rail_a_output_on_o) && rail_b_output_on_o |-> $past(rail_b_above83_i, 3); endproperty
	a_seqb: assert property (p_seqb) else $error("rail a early");
	property p_rel; $fell(supply_supervisor_rst_n_oe_o) |-> n >= RELEASE_CYC && n <= RELEASE_CYC + 4; endproperty
	a_rel: assert property (p_rel) else $error("release delay wrong");
endmodule // drs_monitor
bind drs_sequencer drs_monitor #(.RELEASE_CYC(RELEASE_CYC)) i_drs_monitor (.ref_clk_i, .rst_b_i, .enable_n_i,
	.manual_reset_a_n_i, .manual_reset_b_n_i, .rail_a_above83_i, .rail_a_above95_i, .rail_b_above83_i,
	.rail_b_above95_i, .rail_a_output_on_o, .rail_b_output_on_o, .rail_a_good_flag_oe_o, .supply_supervisor_rst_n_oe_o);
`default_nettype wire

// [tb/tb_drs_sequencer.sv]
// bench of the sequencer: two ramp models on the comparators, ahb-lite master
`timescale 1ns/1ps
`default_nettype none
module tb_drs_sequencer;
	import drs_pkg::*;
	localparam int unsigned R = 20;
	typedef struct packed {logic o; logic [1:0] lead;} drs_row_type;
	drs_row_type rows [2] = '{'{1'h0, 2'h2}, '{1'h1, 2'h1}};
	logic clk = 1'h0, rst_b = 1'h0, en_n = 1'h1, mra = 1'h1, mrb = 1'h1, fa = 1'h0, fb = 1'h0, hwr = 1'h0;
	logic ord = 1'h1;
	logic ce = 1'h1, route = 1'h0;
	logic [1:0] htr = 2'h0;
	logic [31:0] ha = 32'h0, hwd = 32'h0, q;
	wire logic a83, a95, b83, b95, aon, bon, g_oe, r_oe, hrdy, irq;
	wire logic [31:0] hrd;
	int fails = 0, num_checks = 0, k;
	wire logic rst_pin = r_oe ? 1'h0 : 1'h1;
	wire logic g_pin = g_oe ? 1'h0 : 1'h1;
	wire logic mrb_pin = mrb & (~route | g_pin);
	drs_rail_model i_drs_rail_model_a (.clk_i(clk), .on_i(aon), .fault_i(fa), .above83_o(a83), .above95_o(a95));
	drs_rail_model i_drs_rail_model_b (.clk_i(clk), .on_i(bon), .fault_i(fb), .above83_o(b83), .above95_o(b95));
	drs_sequencer #(.RELEASE_CYC(R)) i_drs_sequencer (.ref_clk_i(clk), .rst_b_i(rst_b), .clk_en_i(ce),
		.enable_n_i(en_n), .order_select_i(ord), .manual_reset_a_n_i(mra), .manual_reset_b_n_i(mrb_pin),
		.rail_a_above83_i(a83), .rail_a_above95_i(a95), .rail_b_above83_i(b83), .rail_b_above95_i(b95),
		.rail_a_output_on_o(aon), .rail_b_output_on_o(bon), .rail_a_good_flag_o(), .rail_a_good_flag_oe_o(g_oe),
		.supply_supervisor_rst_n_o(), .supply_supervisor_rst_n_oe_o(r_oe), .hsel_i(1'h1), .haddr_i(ha),
		.htrans_i(htr), .hwrite_i(hwr), .hsize_i(3'h2), .hready_i(hrdy), .hwdata_i(hwd), .hrdata_o(hrd),
		.hreadyout_o(hrdy), .hresp_o(), .irq_o(irq));
	initial forever #12.5 clk = ~clk;
	task automatic chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fails++;
			$display("[ERR] %s expected %0h seen %0h", s, exp, seen);
		end
	endtask
	task automatic cyc(input int c);
		repeat (c) @(negedge clk);
	endtask
	task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk) htr <= 2'h2;
		hwr <= w;
		ha <= {24'h0, a};
		do @(posedge clk); while (hrdy !== 1'h1);
		htr <= 2'h0;
		hwd <= d;
		do @(posedge clk); while (hrdy !== 1'h1);
		q = hrd;
	endtask
	task automatic rel();
		k = 0;
		while (rst_pin !== 1'h1 && k < 200) begin
			@(negedge clk);
			if (a95 && b95 && mra && mrb_pin) k++;
		end
		chk("release", k >= R && k <= R + 4, 1'h1);
		chk("good", g_oe, 1'h0);
	endtask
	task automatic up(input logic [1:0] lead);
		@(posedge clk) en_n <= 1'h0;
		cyc(5);
		chk("leader", {aon, bon}, lead);
		cyc(12);
		chk("both on", {aon, bon}, 2'h3);
		rel();
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	initial begin
		#100000;
		fails++;
		final_report();
	end
	initial begin
		cyc(4);
		@(posedge clk) rst_b <= 1'h1;
		cyc(1);
		chk("reset", {aon, bon, g_oe, r_oe, irq}, 5'h06);
		fork
			ahb(1'h0, OFS_STATUS, 32'h0);
			begin
				@(posedge clk) ce <= 1'h0;
				cyc(2);
				chk("stall", hrdy, 1'h0);
				@(posedge clk) ce <= 1'h1;
			end
		join
		chk("state", q[2:0], 3'h1);
		$display("reset done");
		ahb(1'h0, 8'h40, 32'h0);
		chk("unmapped", q, 32'h0);
		foreach (rows[i]) begin
			@(posedge clk) ord <= rows[i].o;
			up(rows[i].lead);
			@(posedge clk) en_n <= 1'h1;
			cyc(5);
			chk("off", {aon, bon, g_oe, r_oe}, 4'h3);
			$display("row %0d done", i);
		end
		ahb(1'h1, OFS_IRQ_EN, 32'h1 << EV_REL);
		cyc(2);
		chk("irq on", irq, 1'h1);
		ahb(1'h1, OFS_IRQ_EN, 32'h0);
		cyc(2);
		chk("irq masked", irq, 1'h0);
		ahb(1'h0, OFS_IRQ_STAT, 32'h0);
		chk("sticky", q[EV_REL], 1'h1);
		ahb(1'h1, OFS_IRQ_CLR, 32'h1F);
		ahb(1'h1, OFS_IRQ_EN, 32'h1F);
		cyc(2);
		chk("irq clear", irq, 1'h0);
		$display("irq done");
		up(2'h1);
		@(posedge clk) mra <= 1'h0;
		cyc(5);
		chk("manual", {aon, bon, r_oe}, 3'h7);
		@(posedge clk) mra <= 1'h1;
		rel();
		@(posedge clk) fb <= 1'h1;
		cyc(5);
		chk("b low", {aon, r_oe}, 2'h1);
		cyc(6);
		chk("good low", g_oe, 1'h1);
		@(posedge clk) fb <= 1'h0;
		rel();
		@(posedge clk) route <= 1'h1;
		@(posedge clk) fa <= 1'h1;
		cyc(6);
		chk("a fault", {bon, g_oe, r_oe}, 3'h7);
		$display("faults done");
		@(posedge clk) rst_b <= 1'h0;
		cyc(2);
		chk("mid reset", {aon, bon, g_oe, r_oe}, 4'h3);
		@(posedge clk) rst_b <= 1'h1;
		cyc(1);
		chk("after reset", {aon, bon, g_oe, r_oe}, 4'h3);
		$display("mid reset done");
		final_report();
	end
endmodule // tb_drs_sequencer
`default_nettype wire
